// >>> pkg/flash_cmd_pkg.sv
// Package with command codes, status bit positions, register map and modes for the command decoder
// Function
// (RULE1) Two-cycle commands are setup then confirm; single-cycle are setup then data cycle.
// (RULE2) Reads between setup and confirm are serviced; pending command is kept.
// (RULE3) Any other write between setup and confirm sets status bits 7, 5, 4.
// (RULE4) 0060h then 0003h loads read configuration from the address bus.
// (RULE5) 0060h then 0004h loads extended configuration from the address bus.
// (RULE6) After 00C0h the next write stores data into the addressed OTP word or lock.
// (RULE7) 0050h clears all error bits and leaves status bits alone.
// (RULE8) 00FFh puts the addressed partition into array read mode.
// (RULE9) 0070h puts the addressed partition into status read mode.
// (RULE10) 0090h puts the addressed partition into identification read mode.
// (RULE11) 0098h puts the addressed partition into query table read mode.
// (RULE12) After 0041h next write programs one word; partition goes to status read.
// (RULE13) 00E9h then 00D0h is buffered program; data cycles lie between; status read. The code takes none: a command write before 00D0h is a sequence error.
// (RULE14) 0080h then 00D0h starts factory fill; data cycles follow; status read. The code takes no data cycles: it returns to idle after 00D0h.
// (RULE15) 0020h then 00D0h erases the addressed block; partition goes to status read.
// (RULE16) 0060h then 0001h sets the lock bit of the addressed block.
// (RULE17) 0060h then 00D0h clears the lock bit of the addressed block.
// (RULE18) 0060h then 002Fh sets the lock-down bit of the addressed block.
// (RULE19) 00B0h suspends program or erase; sets bit 6 for erase, bit 2 program.
// (RULE20) 00D0h resumes; a nested program suspend resumes before the erase.
// (RULE21) 00BCh then 00D0h blank checks the addressed block; status read mode.
// (RULE22) Command sequence error shows as status bits 5 and 4 both set.
// (RULE23) Error bits are set by the device, cleared only by 0050h or reset.
// (RULE24) Clear status also puts the addressed partition into status read mode.
// (RULE25) Bit 7 low means busy, high means ready.
// (RULE26) A confirm code that does not match the setup aborts with a sequence error.
`default_nettype none
package flash_cmd_pkg;
  // Command codes
  localparam logic [7:0] CMD_LOAD_CFG   = 8'h60;
  localparam logic [7:0] CMD_RCR_CONF   = 8'h03;
  localparam logic [7:0] CMD_ECR_CONF   = 8'h04;
  localparam logic [7:0] CMD_LOCK_CONF  = 8'h01;
  localparam logic [7:0] CMD_LDOWN_CONF = 8'h2f;
  localparam logic [7:0] CMD_CONFIRM    = 8'hd0;
  localparam logic [7:0] CMD_OTP        = 8'hc0;
  localparam logic [7:0] CMD_CLR_STAT   = 8'h50;
  localparam logic [7:0] CMD_RD_ARRAY   = 8'hff;
  localparam logic [7:0] CMD_RD_STAT    = 8'h70;
  localparam logic [7:0] CMD_RD_ID      = 8'h90;
  localparam logic [7:0] CMD_RD_QUERY   = 8'h98;
  localparam logic [7:0] CMD_PROG_WORD  = 8'h41;
  localparam logic [7:0] CMD_PROG_BUF   = 8'he9;
  localparam logic [7:0] CMD_FILL       = 8'h80;
  localparam logic [7:0] CMD_ERASE      = 8'h20;
  localparam logic [7:0] CMD_SUSPEND    = 8'hb0;
  localparam logic [7:0] CMD_BLANK      = 8'hbc;
  // Status bit positions
  localparam int ST_READY   = 7;
  localparam int ST_ESUSP   = 6;
  localparam int ST_ERR_HI  = 5;
  localparam int ST_ERR_LO  = 4;
  localparam int ST_PSUSP   = 2;
  localparam int ST_PART    = 0;
  localparam logic [15:0] STATUS_RESET = 16'h0080;
  localparam logic [15:0] ERROR_MASK   = 16'h033a;
  // APB register byte offsets
  localparam logic [7:0] REG_CMD_DATA = 8'h00;
  localparam logic [7:0] REG_CMD_ADDR = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_RCR      = 8'h0c;
  localparam logic [7:0] REG_ECR      = 8'h10;
  localparam logic [7:0] REG_OP       = 8'h14;
  localparam logic [7:0] REG_MODES    = 8'h18;
  localparam logic [7:0] REG_DONE     = 8'h1c;
  localparam logic [15:0] RCR_RESET   = 16'hbfcf;
  localparam logic [15:0] ECR_RESET   = 16'h0000;
  // Operation codes shown to the array engine
  localparam logic [3:0] OP_NONE = 4'h0;
  localparam logic [3:0] OP_PROG = 4'h1;
  localparam logic [3:0] OP_BUF  = 4'h2;
  localparam logic [3:0] OP_FILL = 4'h3;
  localparam logic [3:0] OP_ERASE = 4'h4;
  localparam logic [3:0] OP_BLANK = 4'h5;
  localparam logic [3:0] OP_LOCK  = 4'h6;
  localparam logic [3:0] OP_UNLOCK = 4'h7;
  localparam logic [3:0] OP_LDOWN = 4'h8;
  localparam logic [3:0] OP_OTP   = 4'h9;
  // Per-partition read modes
  typedef enum logic [1:0] {MODE_ARRAY, MODE_STATUS, MODE_ID, MODE_QUERY} read_mode_e;
endpackage
`default_nettype wire

// >>> rtl/flash_command_decoder.sv
// Command decoder for a partitioned flash device, reached over APB
`timescale 1ns/100ps
`default_nettype none
module flash_command_decoder #(
  parameter int PARTS  = 8,
  parameter int PART_W = 3
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Array engine
  output logic             op_start_o,
  output logic [3:0]       op_code_o,
  output logic [23:0]      op_addr_o,
  output logic [15:0]      op_data_o,
  output logic             op_suspend_o,
  output logic             op_resume_o,
  output logic [PARTS-1:0][1:0] part_mode_o,
  output logic [15:0]      status_o,
  output logic [15:0]      rcr_o,
  output logic [15:0]      ecr_o
);
  // Decoder states: idle, waiting for confirm, waiting for a data write
  typedef enum logic [1:0] {ST_IDLE, ST_CONFIRM, ST_DATA} state_e;

  state_e            state_r;
  logic [7:0]        setup_r;
  logic [23:0]       addr_r;
  logic [15:0]       status_r;
  logic [15:0]       rcr_r;
  logic [15:0]       ecr_r;
  logic [PARTS-1:0][1:0] mode_r;
  logic              busy_r;
  logic              is_erase_r;
  logic              esusp_r;
  logic              psusp_r;
  logic              start_r;
  logic [3:0]        opc_r;
  logic [23:0]       opa_r;
  logic [15:0]       opd_r;
  logic              susp_r;
  logic              resm_r;
  logic [31:0]       rdata_r;

  // Bus decode: one-cycle answer, writes act in the access phase
  wire acc      = psel_i & penable_i;
  wire wr_addr  = acc & pwrite_i & (paddr_i == flash_cmd_pkg::REG_CMD_ADDR);
  wire wr_cmd   = acc & pwrite_i & (paddr_i == flash_cmd_pkg::REG_CMD_DATA);
  wire wr_done  = acc & pwrite_i & (paddr_i == flash_cmd_pkg::REG_DONE);
  wire [7:0] code = pwdata_i[7:0];
  wire [PART_W-1:0] part = addr_r[23 -: PART_W];
  wire known = (paddr_i[7:5] == 3'h0) & (paddr_i[1:0] == 2'b00);
  assign pready_o  = 1'b1;
  assign pslverr_o = acc & ~known;

  // Command classification from the written code
  wire in_idle   = (state_r == ST_IDLE);
  wire want_conf = (code == flash_cmd_pkg::CMD_LOAD_CFG) | (code == flash_cmd_pkg::CMD_PROG_BUF)
                 | (code == flash_cmd_pkg::CMD_FILL) | (code == flash_cmd_pkg::CMD_ERASE)
                 | (code == flash_cmd_pkg::CMD_BLANK);
  wire want_data = (code == flash_cmd_pkg::CMD_OTP) | (code == flash_cmd_pkg::CMD_PROG_WORD);
  wire setup_cfg = (setup_r == flash_cmd_pkg::CMD_LOAD_CFG);
  wire conf_ok = setup_cfg ? ((code == flash_cmd_pkg::CMD_RCR_CONF)
                 | (code == flash_cmd_pkg::CMD_ECR_CONF) | (code == flash_cmd_pkg::CMD_LOCK_CONF)
                 | (code == flash_cmd_pkg::CMD_LDOWN_CONF) | (code == flash_cmd_pkg::CMD_CONFIRM))
                 : (code == flash_cmd_pkg::CMD_CONFIRM); // [RULE26]
  wire do_confirm = wr_cmd & (state_r == ST_CONFIRM) & conf_ok;
  wire bad_conf   = wr_cmd & (state_r == ST_CONFIRM) & ~conf_ok; // [RULE3] [RULE26]
  wire do_data    = wr_cmd & (state_r == ST_DATA);
  wire do_suspend = wr_cmd & in_idle & (code == flash_cmd_pkg::CMD_SUSPEND) & busy_r;
  wire do_resume  = wr_cmd & in_idle & (code == flash_cmd_pkg::CMD_CONFIRM)
                  & (esusp_r | psusp_r);
  wire do_clear   = wr_cmd & in_idle & (code == flash_cmd_pkg::CMD_CLR_STAT);

  // Operation chosen by the setup code, and by the confirm code after 0060h
  logic [3:0] conf_op;
  always_comb begin
    conf_op = flash_cmd_pkg::OP_NONE;
    case (setup_r)
      flash_cmd_pkg::CMD_PROG_BUF: conf_op = flash_cmd_pkg::OP_BUF;     // [RULE13]
      flash_cmd_pkg::CMD_FILL:     conf_op = flash_cmd_pkg::OP_FILL;    // [RULE14]
      flash_cmd_pkg::CMD_ERASE:    conf_op = flash_cmd_pkg::OP_ERASE;   // [RULE15]
      flash_cmd_pkg::CMD_BLANK:    conf_op = flash_cmd_pkg::OP_BLANK;   // [RULE21]
      flash_cmd_pkg::CMD_LOAD_CFG: begin
        if (code == flash_cmd_pkg::CMD_LOCK_CONF) conf_op = flash_cmd_pkg::OP_LOCK;     // [RULE16]
        else if (code == flash_cmd_pkg::CMD_CONFIRM) conf_op = flash_cmd_pkg::OP_UNLOCK; // [RULE17]
        else if (code == flash_cmd_pkg::CMD_LDOWN_CONF) conf_op = flash_cmd_pkg::OP_LDOWN; // [RULE18]
        else conf_op = flash_cmd_pkg::OP_NONE;
      end
      default: conf_op = flash_cmd_pkg::OP_NONE;
    endcase
  end
  wire auto_status = (conf_op == flash_cmd_pkg::OP_BUF) | (conf_op == flash_cmd_pkg::OP_FILL)
                   | (conf_op == flash_cmd_pkg::OP_ERASE) | (conf_op == flash_cmd_pkg::OP_BLANK);
  wire array_op    = auto_status;
  wire data_op_prog = (setup_r == flash_cmd_pkg::CMD_PROG_WORD);

  // Sequencer: only command writes move it; reads never touch it [RULE1] [RULE2]
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= ST_IDLE;
      setup_r <= 8'h00;
    end else if (wr_cmd) begin
      if (in_idle && want_conf) begin
        state_r <= ST_CONFIRM;
        setup_r <= code;
      end else if (in_idle && want_data) begin
        state_r <= ST_DATA;
        setup_r <= code;
      end else begin
        state_r <= ST_IDLE;
      end
    end
  end

  // Address latch for the next command write
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) addr_r <= 24'h000000;
    else if (wr_addr) addr_r <= pwdata_i[23:0];
  end

  // Configuration registers load from the latched address on confirm
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rcr_r <= flash_cmd_pkg::RCR_RESET;
      ecr_r <= flash_cmd_pkg::ECR_RESET;
    end else if (do_confirm && setup_cfg) begin
      if (code == flash_cmd_pkg::CMD_RCR_CONF) rcr_r <= addr_r[15:0]; // [RULE4]
      if (code == flash_cmd_pkg::CMD_ECR_CONF) ecr_r <= addr_r[15:0]; // [RULE5]
    end
  end

  // Per-partition read mode
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_r <= '0;
    end else if (wr_cmd && in_idle) begin
      case (code)
        flash_cmd_pkg::CMD_RD_ARRAY: mode_r[part] <= flash_cmd_pkg::MODE_ARRAY;  // [RULE8]
        flash_cmd_pkg::CMD_RD_STAT:  mode_r[part] <= flash_cmd_pkg::MODE_STATUS; // [RULE9]
        flash_cmd_pkg::CMD_CLR_STAT: mode_r[part] <= flash_cmd_pkg::MODE_STATUS; // [RULE24]
        flash_cmd_pkg::CMD_RD_ID:    mode_r[part] <= flash_cmd_pkg::MODE_ID;     // [RULE10]
        flash_cmd_pkg::CMD_RD_QUERY: mode_r[part] <= flash_cmd_pkg::MODE_QUERY;  // [RULE11]
        default: mode_r <= mode_r;
      endcase
    end else if (do_confirm && auto_status) begin
      mode_r[part] <= flash_cmd_pkg::MODE_STATUS;   // [RULE13] [RULE14] [RULE15] [RULE21]
    end else if (do_data && data_op_prog) begin
      mode_r[part] <= flash_cmd_pkg::MODE_STATUS;   // [RULE12]
    end
  end

  // Operation launch towards the array engine, one-cycle start pulse
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_r <= 1'b0;
      opc_r   <= flash_cmd_pkg::OP_NONE;
      opa_r   <= 24'h000000;
      opd_r   <= 16'h0000;
    end else begin
      start_r <= 1'b0;
      if (do_confirm && conf_op != flash_cmd_pkg::OP_NONE) begin
        start_r <= 1'b1;
        opc_r   <= conf_op;
        opa_r   <= addr_r;
      end else if (do_data) begin
        start_r <= 1'b1;                             // [RULE6] [RULE12]
        opc_r   <= data_op_prog ? flash_cmd_pkg::OP_PROG : flash_cmd_pkg::OP_OTP;
        opa_r   <= addr_r;
        opd_r   <= pwdata_i[15:0];
      end
    end
  end

  // Busy tracking and suspend nesting; a program may run inside an erase suspend
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_r     <= 1'b0;
      is_erase_r <= 1'b0;
      esusp_r    <= 1'b0;
      psusp_r    <= 1'b0;
      susp_r     <= 1'b0;
      resm_r     <= 1'b0;
    end else begin
      susp_r <= do_suspend;
      resm_r <= do_resume;
      if (do_suspend) begin
        busy_r <= 1'b0;
        if (is_erase_r) esusp_r <= 1'b1;            // [RULE19]
        else psusp_r <= 1'b1;                        // [RULE19]
      end else if (do_resume) begin
        busy_r <= 1'b1;
        if (psusp_r) begin
          psusp_r    <= 1'b0;                        // [RULE20]
          is_erase_r <= 1'b0;
        end else begin
          esusp_r    <= 1'b0;
          is_erase_r <= 1'b1;
        end
      end else if ((do_confirm && array_op) || (do_data && data_op_prog)) begin
        busy_r     <= 1'b1;
        is_erase_r <= (conf_op == flash_cmd_pkg::OP_ERASE) & do_confirm;
      end else if (wr_done) begin
        busy_r <= 1'b0;
        if (!is_erase_r && esusp_r) is_erase_r <= 1'b1;
      end
    end
  end

  // Status word: device-set errors win over the clear in the same cycle
  logic [15:0] err_set;
  always_comb begin
    err_set = 16'h0000;
    if (bad_conf) begin
      err_set[flash_cmd_pkg::ST_ERR_HI] = 1'b1;      // [RULE22]
      err_set[flash_cmd_pkg::ST_ERR_LO] = 1'b1;
    end
    if (wr_done) err_set = err_set | (pwdata_i[15:0] & flash_cmd_pkg::ERROR_MASK);
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_r <= flash_cmd_pkg::STATUS_RESET;
    end else begin
      if (do_clear) status_r <= (status_r & ~flash_cmd_pkg::ERROR_MASK) | err_set; // [RULE7] [RULE23]
      else status_r <= status_r | err_set;          // [RULE23]
    end
  end
  // Status bits come from device state; bit 7 high means ready [RULE25] [RULE3]
  logic [15:0] status_view;
  always_comb begin
    status_view = status_r & flash_cmd_pkg::ERROR_MASK;
    status_view[flash_cmd_pkg::ST_READY] = ~busy_r;
    status_view[flash_cmd_pkg::ST_ESUSP] = esusp_r;
    status_view[flash_cmd_pkg::ST_PSUSP] = psusp_r;
    status_view[flash_cmd_pkg::ST_PART]  = busy_r & (opa_r[23 -: PART_W] != part);
  end

  // Read data register
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) rdata_r <= 32'h00000000;
    else if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        flash_cmd_pkg::REG_CMD_ADDR: rdata_r <= {8'h00, addr_r};
        flash_cmd_pkg::REG_STATUS:   rdata_r <= {16'h0000, status_view};
        flash_cmd_pkg::REG_RCR:      rdata_r <= {16'h0000, rcr_r};
        flash_cmd_pkg::REG_ECR:      rdata_r <= {16'h0000, ecr_r};
        flash_cmd_pkg::REG_OP:       rdata_r <= {18'h00000, state_r, opc_r, setup_r};
        flash_cmd_pkg::REG_MODES:    rdata_r <= 32'(mode_r);
        default:                     rdata_r <= 32'h00000000;
      endcase
    end
  end

  assign prdata_o     = rdata_r;
  assign op_start_o   = start_r;
  assign op_code_o    = opc_r;
  assign op_addr_o    = opa_r;
  assign op_data_o    = opd_r;
  assign op_suspend_o = susp_r;
  assign op_resume_o  = resm_r;
  assign part_mode_o  = mode_r;
  assign status_o     = status_view;
  assign rcr_o        = rcr_r;
  assign ecr_o        = ecr_r;

  // Checks
  chk_seq_error: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    bad_conf |=> (status_o[5:4] == 2'b11)) else $error("sequence error not flagged"); // [RULE3]
  chk_rcr_load: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (do_confirm && setup_cfg && code == 8'h03) |=> (rcr_o == $past(addr_r[15:0])))
    else $error("read config not loaded"); // [RULE4]
  chk_ecr_load: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (do_confirm && setup_cfg && code == 8'h04) |=> (ecr_o == $past(addr_r[15:0])))
    else $error("extended config not loaded"); // [RULE5]
  chk_clear_err: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (do_clear && !bad_conf && !wr_done) |=> ((status_o & 16'h033a) == 16'h0000))
    else $error("errors not cleared"); // [RULE7]
  chk_err_sticky: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (status_o[4] && !do_clear) |=> status_o[4]) else $error("error bit lost"); // [RULE23]
  chk_stat_mode: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (wr_cmd && in_idle && code == 8'h70) |=> (part_mode_o[$past(part)] == 2'd1))
    else $error("status mode not set"); // [RULE9]
  chk_erase_susp: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (do_suspend && is_erase_r) |=> (status_o[6] && status_o[7]))
    else $error("erase suspend not shown"); // [RULE19]
  chk_nest_resume: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (do_resume && psusp_r && esusp_r) |=> (!status_o[2] && status_o[6]))
    else $error("nested resume order wrong"); // [RULE20]
  chk_read_keeps: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (state_r == ST_CONFIRM && !wr_cmd) |=> (state_r == ST_CONFIRM))
    else $error("pending command lost"); // [RULE2]
  chk_busy_ready: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
    (do_confirm && conf_op == 4'h4) |=> !status_o[7]) else $error("busy not shown"); // [RULE25]
endmodule
`default_nettype wire

// >>> bench/apb_host_model.sv
// APB master model standing in for the host memory controller
`timescale 1ns/100ps
`default_nettype none
module apb_host_model (
  // Clock
  input  wire logic        clk_sys_i,
  // APB master side
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [7:0]       paddr_o,
  output logic [31:0]      pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);
  // Idle bus at time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 8'h00;
    pwdata_o = 32'h0000_0000;
  end

  // One bus cycle: setup, then access held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_sys_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_sys_i);
    penable_o <= 1'b1;
    do @(posedge clk_sys_i); while (pready_i !== 1'b1);
    rd = prdata_i;
    err = pslverr_i;
    // Released data is inverted so a stale word never looks valid
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    pwdata_o <= ~d;
  endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking testbench for the flash command decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int PARTS = 8;
  localparam int PART_W = 3;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel, penable, pwrite, pready_o, pslverr_o, op_start_o, op_suspend_o, op_resume_o;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata_o, r;
  logic [3:0] op_code_o;
  logic [23:0] op_addr_o, a, b, c;
  logic [15:0] op_data_o, status_o, rcr_o, ecr_o, v;
  logic [PARTS-1:0][1:0] part_mode_o;
  logic e;
  int fail_count = 0;
  int samples_checked = 0;
  int susp_cnt = 0;
  int res_cnt = 0;
  logic [31:0] rd_q[$];
  logic [27:0] op_q[$];
  logic [31:0] lfsr_state = 32'h0000_1846;
  logic [7:0] rm_code [4] = '{8'hff, 8'h70, 8'h90, 8'h98};
  logic [7:0] su_code [7] = '{8'he9, 8'h80, 8'h20, 8'hbc, 8'h60, 8'h60, 8'h60};
  logic [7:0] cf_code [7] = '{8'hd0, 8'hd0, 8'hd0, 8'hd0, 8'h01, 8'hd0, 8'h2f};

  always #5 clk_sys_i = ~clk_sys_i;

  flash_command_decoder #(.PARTS(PARTS), .PART_W(PART_W)) u_flash_command_decoder (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .op_start_o(op_start_o),
    .op_code_o(op_code_o), .op_addr_o(op_addr_o), .op_data_o(op_data_o),
    .op_suspend_o(op_suspend_o), .op_resume_o(op_resume_o), .part_mode_o(part_mode_o),
    .status_o(status_o), .rcr_o(rcr_o), .ecr_o(ecr_o));

  apb_host_model u_apb_host_model (
    .clk_sys_i(clk_sys_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata_o), .pready_i(pready_o),
    .pslverr_i(pslverr_o));

  // Word comparison shared by every check
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Fixed-seed pseudo-random source
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic rnd(output logic [31:0] o);
    lfsr_state = lfsr_next(lfsr_state);
    o = lfsr_state;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] rr;
    logic ee;
    u_apb_host_model.xfer(1'b1, ad, d, rr, ee);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    logic [31:0] rr;
    logic ee;
    rd_q.push_back(exp);
    u_apb_host_model.xfer(1'b0, ad, 32'h0, rr, ee);
  endtask
  // Address goes first, then the command code
  task automatic cmd(input logic [23:0] ad, input logic [7:0] code);
    wr(flash_cmd_pkg::REG_CMD_ADDR, {8'h00, ad});
    wr(flash_cmd_pkg::REG_CMD_DATA, {24'h0, code});
  endtask
  task automatic mode_is(input logic [23:0] ad, input logic [1:0] m);
    chk({30'h0, part_mode_o[ad[23:21]]}, {30'h0, m});
  endtask

  // Monitor: sampled at the edge, before that edge's updates land
  always @(posedge clk_sys_i) begin
    if (psel && penable && !pwrite && pready_o === 1'b1 && rd_q.size() > 0)
      chk(prdata_o, rd_q.pop_front());
    if (op_start_o === 1'b1 && op_q.size() > 0)
      chk({4'h0, op_code_o, op_addr_o}, {4'h0, op_q.pop_front()});
    else if (op_start_o === 1'b1)
      chk(32'h1, 32'h0);
    if (op_suspend_o === 1'b1)
      susp_cnt++;
    if (op_resume_o === 1'b1)
      res_cnt++;
  end

  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog sized well above the few hundred cycles the tests need
  initial begin
    #200000;
    fail_count++;
    $display("watchdog expired");
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rd(flash_cmd_pkg::REG_STATUS, 32'h0080);
    rd(flash_cmd_pkg::REG_ECR, 32'h0000);
    rd(flash_cmd_pkg::REG_RCR, {16'h0, flash_cmd_pkg::RCR_RESET});
    $display("test reset values done");
    // Every read mode in every partition
    for (int p = 0; p < PARTS; p++) begin
      for (int k = 0; k < 4; k++) begin
        rnd(r);
        a = {p[2:0], r[20:0]};
        cmd(a, rm_code[k]);
        @(negedge clk_sys_i);
        mode_is(a, k[1:0]);
      end
    end
    $display("test read modes done");
    // Configuration loads with a read between setup and confirm
    for (int k = 0; k < 2; k++) begin
      rnd(r);
      v = r[15:0];
      cmd({8'h00, v}, 8'h60);
      rd(flash_cmd_pkg::REG_STATUS, 32'h0080);
      wr(flash_cmd_pkg::REG_CMD_DATA, (k == 0) ? 32'h03 : 32'h04);
      rd((k == 0) ? flash_cmd_pkg::REG_RCR : flash_cmd_pkg::REG_ECR, {16'h0, v});
      chk({16'h0, (k == 0) ? rcr_o : ecr_o}, {16'h0, v});
    end
    $display("test config loads done");
    // Two-cycle operations; the first four are busy and switch to status read
    for (int i = 0; i < 7; i++) begin
      rnd(r);
      a = r[23:0];
      op_q.push_back({4'(i + 2), a});
      cmd(a, su_code[i]);
      wr(flash_cmd_pkg::REG_CMD_DATA, {24'h0, cf_code[i]});
      @(negedge clk_sys_i);
      if (i < 4)
        mode_is(a, 2'd1);
      chk({31'h0, status_o[7]}, (i < 4) ? 32'h0 : 32'h1);
      wr(flash_cmd_pkg::REG_DONE, 32'h0);
    end
    $display("test two-cycle operations done");
    // Erase, suspend, resume, then the done write
    a = 24'h45_6789;
    op_q.push_back({4'h4, a});
    cmd(a, 8'h20);
    wr(flash_cmd_pkg::REG_CMD_DATA, 32'hd0);
    rd(flash_cmd_pkg::REG_STATUS, 32'h0000);
    wr(flash_cmd_pkg::REG_CMD_DATA, 32'hb0);
    @(negedge clk_sys_i);
    chk({31'h0, status_o[6]}, 32'h1);
    wr(flash_cmd_pkg::REG_CMD_DATA, 32'hd0);
    @(negedge clk_sys_i);
    chk({31'h0, status_o[6]}, 32'h0);
    wr(flash_cmd_pkg::REG_DONE, 32'h0);
    rd(flash_cmd_pkg::REG_STATUS, 32'h0080);
    // Single word program with a program suspend
    rnd(r);
    a = r[23:0];
    v = r[31:16];
    op_q.push_back({4'h1, a});
    cmd(a, 8'h41);
    wr(flash_cmd_pkg::REG_CMD_DATA, {16'h0, v});
    @(negedge clk_sys_i);
    chk({16'h0, op_data_o}, {16'h0, v});
    mode_is(a, 2'd1);
    wr(flash_cmd_pkg::REG_CMD_DATA, 32'hb0);
    @(negedge clk_sys_i);
    chk({31'h0, status_o[2]}, 32'h1);
    wr(flash_cmd_pkg::REG_CMD_DATA, 32'hd0);
    @(negedge clk_sys_i);
    chk({31'h0, status_o[2]}, 32'h0);
    wr(flash_cmd_pkg::REG_DONE, 32'h0);
    wr(flash_cmd_pkg::REG_CMD_DATA, 32'hb0);
    wr(flash_cmd_pkg::REG_CMD_DATA, 32'hd0);
    chk(susp_cnt, 2);
    chk(res_cnt, 2);
    // OTP word written by the following data cycle
    op_q.push_back({4'h9, a});
    cmd(a, 8'hc0);
    wr(flash_cmd_pkg::REG_CMD_DATA, {16'h0, ~v});
    @(negedge clk_sys_i);
    chk({16'h0, op_data_o}, {16'h0, ~v});
    rd(flash_cmd_pkg::REG_OP, 32'h0000_09c0);
    // Program nested inside an erase suspend must resume before the erase
    op_q.push_back({4'h4, a});
    cmd(a, 8'h20);
    wr(flash_cmd_pkg::REG_CMD_DATA, 32'hd0);
    wr(flash_cmd_pkg::REG_CMD_DATA, 32'hb0);
    op_q.push_back({4'h1, a});
    cmd(a, 8'h41);
    wr(flash_cmd_pkg::REG_CMD_DATA, {16'h0, v});
    wr(flash_cmd_pkg::REG_CMD_DATA, 32'hb0);
    wr(flash_cmd_pkg::REG_CMD_DATA, 32'hd0);
    @(negedge clk_sys_i);
    chk({30'h0, status_o[6], status_o[2]}, 32'h2);
    wr(flash_cmd_pkg::REG_DONE, 32'h0);
    wr(flash_cmd_pkg::REG_CMD_DATA, 32'hd0);
    @(negedge clk_sys_i);
    chk({30'h0, status_o[6], status_o[7]}, 32'h0);
    wr(flash_cmd_pkg::REG_DONE, 32'h0);
    $display("test suspend, program and otp done");
    // Sequence errors: a write between the two cycles, then a mismatched confirm
    a = 24'ha0_0000;
    b = 24'hc0_0000;
    c = 24'he0_0000;
    cmd(b, 8'hff);
    cmd(c, 8'hff);
    cmd(a, 8'h20);
    wr(flash_cmd_pkg::REG_CMD_DATA, 32'h70);
    @(negedge clk_sys_i);
    chk({16'h0, status_o}, 32'h00b0);
    cmd(a, 8'h60);
    wr(flash_cmd_pkg::REG_CMD_DATA, 32'h99);
    cmd(a, 8'h70);
    rd(flash_cmd_pkg::REG_STATUS, 32'h00b0);
    wr(flash_cmd_pkg::REG_DONE, 32'h0002);
    rd(flash_cmd_pkg::REG_STATUS, 32'h00b2);
    cmd(b, 8'h50);
    @(negedge clk_sys_i);
    chk({16'h0, status_o}, 32'h0080);
    mode_is(b, 2'd1);
    mode_is(c, 2'd0);
    rd(flash_cmd_pkg::REG_CMD_ADDR, {8'h00, b});
    $display("test sequence errors done");
    // Unmapped address is refused with read data zero
    rd_q.push_back(32'h0);
    u_apb_host_model.xfer(1'b0, 8'h20, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    repeat (2) @(posedge clk_sys_i);
    chk(op_q.size() + rd_q.size(), 0);
    $display("test unmapped access done");
    report_and_stop();
  end
endmodule
`default_nettype wire
